// ===== design/lvds_serializer_pkg.sv
// Shared constants for the 28-to-4 pixel serializer
package lvds_serializer_pkg;
  // Word and lane geometry
  localparam int PIXEL_BITS = 28;
  localparam int LANE_COUNT = 4;
  localparam int SLOT_COUNT = 7;
  localparam logic [2:0] LAST_SLOT = 3'h6;
  // Forwarded clock is high for the first slots of each word
  localparam logic [2:0] FWD_HIGH_SLOTS = 3'h4;
  // Pixel clock period in ns (20 MHz)
  localparam int CLK_PERIOD_NS = 50;
  // Longest lock time of the clock multiplier, in ms
  localparam int PLL_LOCK_TIME_MS = 10;
  localparam int PLL_LOCK_CYC = (PLL_LOCK_TIME_MS * 1000000) / CLK_PERIOD_NS;
  localparam int LOCK_W = 18;
  // Longest power-down entry time, in ns, and its cycle count
  localparam int POWER_DOWN_DELAY_NS = 100;
  localparam int POWER_DOWN_DELAY_CYC = POWER_DOWN_DELAY_NS / CLK_PERIOD_NS;
  // Lane rate at the top pixel rate
  localparam int MAX_PIXEL_MHZ = 65;
  localparam int LANE_MBPS = MAX_PIXEL_MHZ * SLOT_COUNT;
  // Reset values
  localparam logic [PIXEL_BITS-1:0] WORD_RESET = 28'h0000000;
  localparam logic [LOCK_W-1:0] LOCK_RESET = 18'h00000;
endpackage : lvds_serializer_pkg

// ===== design/lvds_pixel_serializer_28to4.sv
// Parallel pixel capture and four-lane serializer with forwarded clock
// Contract
// - Capture all 28 inputs every clock cycle
// - Forward a word-locked clock on fifth lane
// - Sample inputs on falling clock edge
// - Seven slots per word, bit 0 first
// - Power-down low disables all serial outputs
// - Power-down entry completes within 100 ns
// - Output trusted only after multiplier lock time
// - Lane carries seven bits per input cycle
`timescale 1ns/1ps
`default_nettype none
module lvds_pixel_serializer_28to4
  import lvds_serializer_pkg::*;
#(
  parameter int LOCK_CYCLES = PLL_LOCK_CYC
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic serial_bit_clock,
  input wire logic [PIXEL_BITS-1:0] parallel_pixel_inputs,
  input wire logic power_down_n,
  output logic [LANE_COUNT-1:0] serial_lane_outputs,
  output logic forwarded_link_clock,
  output logic lane_output_enable,
  output logic link_locked
);

  localparam logic [LOCK_W-1:0] LOCK_LAST = LOCK_W'(LOCK_CYCLES - 1);

  // Pixel-clock side state, all on the falling edge
  typedef struct packed {
    logic pd_meta;                    // Power-down pin, first stage
    logic pd_sync;                    // Power-down pin, synchronised
    logic [LOCK_W-1:0] lock_count;    // Lock wait counter
    logic locked;                     // Multiplier settled
    logic [PIXEL_BITS-1:0] word;      // Captured pixel word
    logic word_toggle;                // Flips on every capture
  } pix_s;

  // Bit-clock side state
  typedef struct packed {
    logic rst_meta;                   // Reset crossing, first stage
    logic rst_sync;                   // Reset in link domain
    logic tog_meta;                   // Capture toggle, first stage
    logic tog_sync;                   // Capture toggle, synchronised
    logic tog_seen;                   // Last toggle taken
    logic lock_meta;                  // Lock flag, first stage
    logic lock_sync;                  // Lock flag, synchronised
    logic [PIXEL_BITS-1:0] pending;   // Newest word from pixel side
    logic [PIXEL_BITS-1:0] shift;     // Word being sent
    logic [2:0] slot;                 // Current bit slot
    logic [LANE_COUNT-1:0] lanes;     // Registered lane bits
    logic fwd_clk;                    // Registered forwarded clock
  } link_s;

  pix_s pix;
  pix_s next_pix;
  link_s lk;
  link_s next_lk;
  logic running;                      // Link is locked and out of reset
  logic [LANE_COUNT-1:0] expect_lanes;

  // Pixel side: capture, power-down sync and lock timer
  always_comb begin
    next_pix = pix;
    next_pix.pd_meta = power_down_n;
    next_pix.pd_sync = pix.pd_meta;
    // Capture the whole word on each falling edge
    next_pix.word = parallel_pixel_inputs;
    next_pix.word_toggle = ~pix.word_toggle;
    if (!pix.pd_sync) begin
      // Powered down: drop lock and restart the wait
      next_pix.lock_count = LOCK_RESET;
      next_pix.locked = 1'b0;
    end else if (!pix.locked) begin
      // Waiting for the multiplier to settle
      next_pix.lock_count = pix.lock_count + 1'b1;
      next_pix.locked = (pix.lock_count == LOCK_LAST);
    end
  end

  // Pixel side register
  always_ff @(negedge clk) begin
    if (reset) begin
      pix <= '{pd_meta: 1'b0, pd_sync: 1'b0, lock_count: LOCK_RESET,
               locked: 1'b0, word: WORD_RESET, word_toggle: 1'b0};
    end else begin
      pix <= next_pix;
    end
  end

  assign running = lk.lock_sync && !lk.rst_sync;

  // Lane bits for the current slot: lane l sends bits 7l..7l+6
  always_comb begin
    expect_lanes = '0;
    for (int l = 0; l < LANE_COUNT; l++) begin
      expect_lanes[l] = lk.shift[l * SLOT_COUNT + int'(lk.slot)];
    end
  end

  // Link side: crossings, slot counter and lane shifting
  always_comb begin
    next_lk = lk;
    next_lk.rst_meta = reset;
    next_lk.rst_sync = lk.rst_meta;
    next_lk.tog_meta = pix.word_toggle;
    next_lk.tog_sync = lk.tog_meta;
    next_lk.tog_seen = lk.tog_sync;
    next_lk.lock_meta = pix.locked;
    next_lk.lock_sync = lk.lock_meta;
    // Word is held a full pixel period, so it is stable here
    if (lk.tog_sync != lk.tog_seen) begin
      next_lk.pending = pix.word;
    end
    if (lk.rst_sync) begin
      // Reset reached the link domain
      next_lk.pending = WORD_RESET;
      next_lk.shift = WORD_RESET;
      next_lk.slot = 3'h0;
      next_lk.lanes = '0;
      next_lk.fwd_clk = 1'b0;
    end else if (!lk.lock_sync) begin
      // Not locked: hold at slot zero, lanes quiet
      next_lk.shift = lk.pending;
      next_lk.slot = 3'h0;
      next_lk.lanes = '0;
      next_lk.fwd_clk = 1'b0;
    end else begin
      // Send one slot of each lane, bit 0 first
      next_lk.lanes = expect_lanes;
      next_lk.fwd_clk = (lk.slot < FWD_HIGH_SLOTS);
      if (lk.slot == LAST_SLOT) begin
        // Word done: start the newest one at slot zero
        next_lk.slot = 3'h0;
        next_lk.shift = lk.pending;
      end else begin
        next_lk.slot = lk.slot + 3'h1;
      end
    end
  end

  // Link side register
  always_ff @(posedge serial_bit_clock) begin
    lk <= next_lk;
  end

  // Outputs straight from flip-flops
  assign serial_lane_outputs = lk.lanes;
  assign forwarded_link_clock = lk.fwd_clk;
  assign lane_output_enable = pix.pd_sync;
  assign link_locked = pix.locked;

  // Pixel side checks
  AST_CAPTURE: assert property (@(negedge clk) disable iff (reset)
    !reset |=> (pix.word == $past(parallel_pixel_inputs))
         && (pix.word_toggle != $past(pix.word_toggle)))
    else $error("pixel word not captured on falling edge");

  AST_PD_ENTRY: assert property (@(negedge clk) disable iff (reset)
    (!power_down_n [*2]) |=> !lane_output_enable)
    else $error("outputs still enabled after power-down delay");

  AST_PD_EXIT: assert property (@(negedge clk) disable iff (reset)
    (!reset && power_down_n) ##1 power_down_n |=> lane_output_enable)
    else $error("outputs not enabled with power-down released");

  AST_PD_UNLOCK: assert property (@(negedge clk) disable iff (reset)
    !lane_output_enable |=> !link_locked && (pix.lock_count == LOCK_RESET))
    else $error("lock kept while powered down");

  AST_LOCK_WAIT: assert property (@(negedge clk) disable iff (reset)
    $rose(link_locked) |-> ($past(pix.lock_count) == LOCK_LAST)
                         && lane_output_enable)
    else $error("lock declared before lock time");

  // Link side checks
  AST_SLOT_STEP: assert property (@(posedge serial_bit_clock)
    disable iff (lk.rst_sync)
    running && (lk.slot != LAST_SLOT) |=> lk.slot == $past(lk.slot) + 3'h1)
    else $error("slot did not advance");

  AST_SLOT_WRAP: assert property (@(posedge serial_bit_clock)
    disable iff (lk.rst_sync)
    running && (lk.slot == LAST_SLOT) |=> (lk.slot == 3'h0))
    else $error("slot did not wrap after seven");

  // Word shifted down by the slot: each group's current bit lands at 7l
  logic [PIXEL_BITS-1:0] lane_peek;
  assign lane_peek = lk.shift >> lk.slot;

  AST_LANE_MAP: assert property (@(posedge serial_bit_clock)
    disable iff (lk.rst_sync)
    running |=> serial_lane_outputs == {$past(lane_peek[3 * SLOT_COUNT]),
      $past(lane_peek[2 * SLOT_COUNT]), $past(lane_peek[SLOT_COUNT]),
      $past(lane_peek[0])})
    else $error("lane bit does not match its group");

  AST_FWD_CLOCK: assert property (@(posedge serial_bit_clock)
    disable iff (lk.rst_sync)
    running |=> forwarded_link_clock == ($past(lk.slot) < FWD_HIGH_SLOTS))
    else $error("forwarded clock out of phase with slots");

  AST_RESTART: assert property (@(posedge serial_bit_clock)
    disable iff (lk.rst_sync)
    !running |=> (lk.slot == 3'h0) && (serial_lane_outputs == '0))
    else $error("serializer not parked at slot zero");

  // Main scenarios
  COV_LOCK: cover property (@(negedge clk) disable iff (reset)
    $rose(link_locked));
  COV_PD: cover property (@(negedge clk) disable iff (reset)
    link_locked ##1 !lane_output_enable);
  COV_WORD: cover property (@(posedge serial_bit_clock)
    disable iff (lk.rst_sync)
    running && (lk.slot == LAST_SLOT) ##1 running && (lk.slot == 3'h0));
  COV_RELEASE: cover property (@(negedge clk) disable iff (reset)
    !lane_output_enable ##1 lane_output_enable);

endmodule : lvds_pixel_serializer_28to4
`default_nettype wire

// ===== verif/lvds_lane_receiver.sv
// Panel-side receiver model for the four-lane link
`timescale 1ns/1ps
`default_nettype none
module lvds_lane_receiver
  import lvds_serializer_pkg::*;
(
  input wire logic bclk,
  input wire logic en,
  input wire logic [LANE_COUNT-1:0] lanes,
  input wire logic fwd,
  output logic [PIXEL_BITS-1:0] word,
  output logic valid
);
  logic [PIXEL_BITS-1:0] acc; // Word being assembled
  int slot = 7; // Slot index, 7 while idle
  logic fwd_q = 1'b0; // Forwarded clock one bit earlier
  // Rising forwarded clock marks slot 0; lane l slot s is bit 7l+s
  always @(posedge bclk) begin
    valid <= 1'b0;
    fwd_q <= fwd & en;
    if (!en) begin
      slot = 7; // Lanes floating, drop the word
    end else begin
      if (fwd && !fwd_q) slot = 0;
      if (slot < SLOT_COUNT) begin
        // Same group mapping as the transmitter, chosen by the system
        for (int l = 0; l < LANE_COUNT; l++) begin
          acc[SLOT_COUNT*l+slot] = lanes[l];
        end
        if (slot == SLOT_COUNT - 1) begin
          word <= acc;
          valid <= 1'b1;
        end
        slot++;
      end
    end
  end
endmodule : lvds_lane_receiver
`default_nettype wire

// ===== verif/lvds_pixel_serializer_28to4_tb.sv
// Self-checking bench for the 28-to-4 pixel serializer
`timescale 1ns/1ps
`default_nettype none
module lvds_pixel_serializer_28to4_tb;
  import lvds_serializer_pkg::*;
  localparam int LK = 16; // Shortened lock wait
  logic clk = 1'b0, bclk = 1'b0, reset = 1'b1, pd_n = 1'b1;
  logic [PIXEL_BITS-1:0] din = WORD_RESET; // Pixel word driven
  logic [PIXEL_BITS-1:0] rx_w; // Word from receiver
  logic [LANE_COUNT-1:0] lanes;
  logic fwd, oe, locked, rx_v;
  logic [PIXEL_BITS-1:0] hist [$]; // Recently captured words
  logic [31:0] seed = 32'h42a6; // Xorshift state
  int miscompares = 0, n_compared = 0, rx_n = 0, cnt, base;
  // 20 MHz pixel clock, inside the allowed shift clock range
  always #25 clk = ~clk;
  // Bit clock, offset so its edges never meet the pixel clock's
  initial begin
    #3.3;
    forever #6 bclk = ~bclk;
  end
  lvds_pixel_serializer_28to4 #(.LOCK_CYCLES(LK))
    lvds_pixel_serializer_28to4_i (.clk(clk), .reset(reset),
    .serial_bit_clock(bclk), .parallel_pixel_inputs(din),
    .power_down_n(pd_n), .serial_lane_outputs(lanes),
    .forwarded_link_clock(fwd), .lane_output_enable(oe),
    .link_locked(locked));
  lvds_lane_receiver lvds_lane_receiver_i (.bclk(bclk), .en(oe),
    .lanes(lanes), .fwd(fwd), .word(rx_w), .valid(rx_v));
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs
  task automatic check(input logic ok, input string msg);
    n_compared++;
    if (ok !== 1'b1) begin
      miscompares++;
      $display("Error %0t %s", $time, msg);
    end
  endtask : check
  task automatic report_and_stop;
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : report_and_stop
  // Wait for enable, then count pixel edges until lock
  task automatic lock_wait;
    cnt = 0;
    while (oe !== 1'b1 && cnt < 10) begin
      @(negedge clk);
      #1 cnt++;
    end
    check(oe === 1'b1, "outputs not enabled");
    cnt = 0;
    while (locked !== 1'b1 && cnt < LK + 8) begin
      @(negedge clk);
      #1 cnt++;
    end
    check(cnt >= LK && cnt <= LK + 1, "lock wait wrong");
    if (locked !== 1'b1) report_and_stop();
  endtask : lock_wait
  // Wait for a number of further received words
  task automatic stream(input int n);
    base = rx_n;
    cnt = 0;
    while (rx_n < base + n && cnt < 200) begin
      @(negedge clk);
      cnt++;
    end
    check(rx_n >= base + n, "too few words");
    if (rx_n < base + n) report_and_stop();
  endtask : stream
  // Random words on the falling edge; model keeps what was sampled
  always @(negedge clk) begin
    hist.push_front(din);
    if (hist.size() > 8) hist.pop_back();
    seed = xs(seed);
    din <= seed[PIXEL_BITS-1:0];
  end
  // Every received word must be a recently captured input
  always @(posedge bclk) if (rx_v === 1'b1) begin
    rx_n++;
    check(rx_w inside {hist}, "lane word not an input");
  end
  initial begin
    repeat (4) @(posedge clk);
    @(negedge clk) reset <= 1'b0;
    lock_wait();
    stream(20);
    $display("test start and stream done");
    @(negedge clk) pd_n <= 1'b0;
    repeat (2) @(negedge clk);
    #1 check(oe === 1'b0, "outputs still driven");
    repeat (7) @(negedge clk);
    #1 check(locked === 1'b0, "still locked");
    check(lanes === 4'h0 && fwd === 1'b0, "lanes not parked");
    $display("test power down done");
    @(negedge clk) pd_n <= 1'b1;
    lock_wait();
    stream(20);
    $display("test relock done");
    report_and_stop();
  end
endmodule : lvds_pixel_serializer_28to4_tb
`default_nettype wire
